// File: hdl/fdr_host_ctrl.sv
// Host controller that reads identification, signature, unique id and parameter data.
// Contract
// - Identification read is command 90H then one address cycle 00H.
// - Command 90H address 20H returns 4FH 4EH 46H 49H; later bytes unreliable.
// - Identifier is followed by its complement; copy valid when XOR is all ones.
// - Host moves the output position with 05H, column, E0H.
// - After status polling the host writes 00H before data output resumes.
// - Random data output during parameter read continues from the new column.
// - After status polling during parameter read the host writes 00H.
// - CRC starts at 4F4Eh, no final XOR, no bit reversal.
//
// Added by the designer: the placing of the registers and the plain strobed port.
module fdr_host_ctrl (
   input  wire logic             core_clk_i,
   input  wire logic             rst_b_i,
   input  wire fdr_pkg::fdr_bus_s host_bus_i,
   output logic [31:0]           host_rdata_o,
   input  wire logic [7:0]       nand_io_i,
   input  wire logic             nand_rb_i,
   output fdr_pkg::fdr_pin_s     nand_o
);
   import fdr_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE, S_LOAD, S_SETUP, S_WE_LO, S_WE_HI, S_WAIT, S_RB, S_RE_LO, S_RE_HI
   } fdr_state_e;

   // ==========================================================
   // Pin synchronisers.
   logic [7:0] io_m;
   logic [7:0] io_s;
   logic       rb_m;
   logic       rb_s;

   always_ff @(posedge core_clk_i) begin
      io_m <= nand_io_i;
      io_s <= io_m;
      rb_m <= nand_rb_i;
      rb_s <= rb_m;
   end

   // ==========================================================
   // Sequencer state and command decode.
   fdr_state_e state;
   fdr_op_e    op;
   logic [2:0] step;
   logic [3:0] tmr;
   logic [9:0] cnt;
   logic [9:0] idx;
   logic [11:0] col;
   logic [2:0] lat_n;
   logic [7:0] lat_byte;
   logic       lat_cmd;
   logic       wait_rb;

   wire        ctrl_wr  = host_bus_i.wr && (host_bus_i.addr == REG_CTRL);
   wire [2:0]  new_opc  = host_bus_i.wdata[CTRL_OP_LSB +: 3];
   wire        launch   = ctrl_wr && (state == S_IDLE) && (new_opc <= OP_MAX);
   wire fdr_op_e new_op = fdr_op_e'(new_opc);
   wire [9:0]  new_cnt  = host_bus_i.wdata[CTRL_CNT_LSB +: 10];
   wire        last_lat = (step == lat_n - 3'h1);
   wire        cap      = (state == S_RE_LO) && (tmr == 4'h0);
   wire        done_rd  = (idx == cnt);

   always_comb begin
      lat_n    = 3'h1;
      lat_byte = CMD_STATUS;
      lat_cmd  = 1'h1;
      wait_rb  = 1'h0;
      case (op)
         OP_ID: begin
            lat_n    = 3'h2;
            lat_byte = (step == 3'h0) ? CMD_READ_ID : ADDR_ID;
            lat_cmd  = (step == 3'h0);
         end
         OP_SIG: begin
            lat_n    = 3'h2;
            lat_byte = (step == 3'h0) ? CMD_READ_ID : ADDR_SIG;
            lat_cmd  = (step == 3'h0);
         end
         OP_UID: begin
            lat_n    = 3'h2;
            lat_byte = (step == 3'h0) ? CMD_UID : ADDR_INFO;
            lat_cmd  = (step == 3'h0);
            wait_rb  = 1'h1;
         end
         OP_PARAM: begin
            lat_n    = 3'h2;
            lat_byte = (step == 3'h0) ? CMD_PARAM : ADDR_INFO;
            lat_cmd  = (step == 3'h0);
            wait_rb  = 1'h1;
         end
         OP_RND: begin
            lat_n    = 3'h4;
            lat_cmd  = (step == 3'h0) || (step == 3'h3);
            case (step)
               3'h0:    lat_byte = CMD_RND;
               3'h1:    lat_byte = col[7:0];
               3'h2:    lat_byte = {4'h0, col[11:8]};
               default: lat_byte = CMD_RND_CFM;
            endcase
         end
         OP_RESUME: lat_byte = CMD_RESUME;
         default: lat_byte = CMD_STATUS;
      endcase
   end

   // ==========================================================
   // Pin sequencer.
   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         state  <= S_IDLE;
         nand_o <= PIN_IDLE;
         op     <= OP_ID;
         step   <= 3'h0;
         tmr    <= 4'h0;
         cnt    <= 10'h000;
         idx    <= 10'h000;
         col    <= 12'h000;
      end else begin
         case (state)
            S_IDLE: if (launch) begin
               op          <= new_op;
               cnt         <= (new_op == OP_SIG) ? SIG_LEN : new_cnt;
               col         <= host_bus_i.wdata[CTRL_COL_LSB +: 12];
               step        <= 3'h0;
               idx         <= 10'h000;
               nand_o.ce_n <= 1'h0;
               state       <= S_LOAD;
            end
            S_LOAD: begin
               nand_o.cle     <= lat_cmd;
               nand_o.ale     <= !lat_cmd;
               nand_o.io      <= lat_byte;
               nand_o.io_oe_n <= 1'h0;
               state          <= S_SETUP;
            end
            S_SETUP: begin
               nand_o.we_n <= 1'h0;
               tmr         <= WE_LO_CYC - 4'h1;
               state       <= S_WE_LO;
            end
            S_WE_LO: if (tmr == 4'h0) begin
               nand_o.we_n <= 1'h1;
               tmr         <= WE_HI_CYC - 4'h1;
               state       <= S_WE_HI;
            end else begin
               tmr <= tmr - 4'h1;
            end
            S_WE_HI: if (tmr != 4'h0) begin
               tmr <= tmr - 4'h1;
            end else if (last_lat) begin
               nand_o.cle     <= 1'h0;
               nand_o.ale     <= 1'h0;
               nand_o.io_oe_n <= 1'h1;
               tmr            <= wait_rb ? TWB_CYC - 4'h1 : TWHR_CYC - 4'h1;
               state          <= S_WAIT;
            end else begin
               step  <= step + 3'h1;
               state <= S_LOAD;
            end
            S_WAIT: if (tmr != 4'h0) begin
               tmr <= tmr - 4'h1;
            end else if (wait_rb) begin
               state <= S_RB;
            end else if (done_rd) begin
               nand_o.ce_n <= 1'h1;
               state       <= S_IDLE;
            end else begin
               nand_o.re_n <= 1'h0;
               tmr         <= RE_LO_CYC - 4'h1;
               state       <= S_RE_LO;
            end
            S_RB: if (rb_s && done_rd) begin
               nand_o.ce_n <= 1'h1;
               state       <= S_IDLE;
            end else if (rb_s) begin
               nand_o.re_n <= 1'h0;
               tmr         <= RE_LO_CYC - 4'h1;
               state       <= S_RE_LO;
            end
            S_RE_LO: if (tmr == 4'h0) begin
               nand_o.re_n <= 1'h1;
               idx         <= idx + 10'h001;
               tmr         <= RE_HI_CYC - 4'h1;
               state       <= S_RE_HI;
            end else begin
               tmr <= tmr - 4'h1;
            end
            S_RE_HI: if (tmr != 4'h0) begin
               tmr <= tmr - 4'h1;
            end else if (done_rd) begin
               nand_o.ce_n <= 1'h1;
               state       <= S_IDLE;
            end else begin
               nand_o.re_n <= 1'h0;
               tmr         <= RE_LO_CYC - 4'h1;
               state       <= S_RE_LO;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ==========================================================
   // Captured data and checks.
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         if (r[15] ^ d[i]) begin
            r = {r[14:0], 1'h0} ^ CRC_POLY;
         end else begin
            r = {r[14:0], 1'h0};
         end
      end
      return r;
   endfunction

   logic [7:0]  id_mem  [0:4];
   logic [7:0]  uid_mem [0:15];
   logic [7:0]  last_data;
   logic [11:0] pos;
   logic        stream_uid;
   logic        sig_ok;
   logic        uid_ok;
   logic        uid_bad;
   logic        crc_ok;
   logic [15:0] crc;
   logic [7:0]  crc_lo;

   wire [7:0] sig_byte = (idx[1:0] == 2'h0) ? SIG_B0 : (idx[1:0] == 2'h1) ? SIG_B1 :
                         (idx[1:0] == 2'h2) ? SIG_B2 : SIG_B3;
   wire str_op  = (op == OP_UID) || (op == OP_PARAM) || (op == OP_RND) || (op == OP_RESUME);
   wire uid_act = cap && str_op && stream_uid;
   wire par_act = cap && str_op && !stream_uid;
   wire uid_mis = (uid_mem[pos[3:0]] ^ io_s) != UID_CPL;

   always_ff @(posedge core_clk_i) begin
      if (cap && (op == OP_ID) && (idx < ID_LEN)) begin
         id_mem[idx[2:0]] <= io_s;
      end
      if (uid_act && !pos[4]) begin
         uid_mem[pos[3:0]] <= io_s;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         last_data  <= 8'h00;
         pos        <= 12'h000;
         stream_uid <= 1'h0;
         sig_ok     <= 1'h0;
         uid_ok     <= 1'h0;
         uid_bad    <= 1'h0;
         crc_ok     <= 1'h0;
         crc        <= CRC_INIT;
         crc_lo     <= 8'h00;
      end else begin
         if (launch && ((new_op == OP_UID) || (new_op == OP_PARAM))) begin
            pos        <= 12'h000;
            stream_uid <= (new_op == OP_UID);
            uid_ok     <= 1'h0;
            crc_ok     <= 1'h0;
            crc        <= CRC_INIT;
         end else if (launch && (new_op == OP_RND)) begin
            pos <= host_bus_i.wdata[CTRL_COL_LSB +: 12];
         end else if (cap && str_op) begin
            pos <= pos + 12'h001;
         end
         if (launch && (new_op == OP_SIG)) begin
            sig_ok <= 1'h1;
         end else if (cap && (op == OP_SIG) && (io_s != sig_byte)) begin
            sig_ok <= 1'h0;
         end
         if (cap) begin
            last_data <= io_s;
         end
         if (uid_act && (pos[4:0] == 5'h00)) begin
            uid_bad <= 1'h0;
         end else if (uid_act && pos[4] && uid_mis) begin
            uid_bad <= 1'h1;
            uid_ok  <= 1'h0;
         end else if (uid_act && (pos[4:0] == 5'h1F) && !uid_bad) begin
            uid_ok <= 1'h1;
         end
         // CRC over bytes before the check field.
         if (par_act && (pos[7:0] < CRC_LO_POS)) begin
            crc <= crc_step(crc, io_s);
         end else if (par_act && (pos[7:0] == CRC_LO_POS)) begin
            crc_lo <= io_s;
         end else if (par_act && (pos[7:0] == CRC_HI_POS)) begin
            crc_ok <= ({io_s, crc_lo} == crc);
            crc    <= CRC_INIT;
         end
      end
   end

   // ==========================================================
   // Register read port.
   wire [31:0] stat_word = {6'h00, idx, 8'h00, 3'h0, crc_ok, uid_ok, sig_ok, rb_s,
                            state != S_IDLE};
   wire [31:0] rd_word =
      (host_bus_i.addr == REG_CTRL) ? {29'h0, op} :
      (host_bus_i.addr == REG_STAT) ? stat_word :
      (host_bus_i.addr == REG_DATA) ? {24'h0, last_data} :
      (host_bus_i.addr == REG_ID0)  ? {id_mem[3], id_mem[2], id_mem[1], id_mem[0]} :
      (host_bus_i.addr == REG_ID1)  ? {24'h0, id_mem[4]} :
      (host_bus_i.addr == REG_UID0) ? {uid_mem[3], uid_mem[2], uid_mem[1], uid_mem[0]} :
      (host_bus_i.addr == REG_UID1) ? {uid_mem[7], uid_mem[6], uid_mem[5], uid_mem[4]} :
      (host_bus_i.addr == REG_UID2) ? {uid_mem[11], uid_mem[10], uid_mem[9], uid_mem[8]} :
      (host_bus_i.addr == REG_UID3) ? {uid_mem[15], uid_mem[14], uid_mem[13], uid_mem[12]} :
      (host_bus_i.addr == REG_CRC)  ? {crc_lo, 8'h00, crc} : 32'h0;

   always_ff @(posedge core_clk_i) begin
      if (!rst_b_i) begin
         host_rdata_o <= 32'h0;
      end else begin
         host_rdata_o <= host_bus_i.rd ? rd_word : 32'h0;
      end
   end

   // ==========================================================
   // Assertions.
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_id_cmd_byte: assert property (
      (state == S_SETUP && op == OP_ID && nand_o.cle) |-> nand_o.io == CMD_READ_ID)
      else $error("Identification command byte wrong.");
   chk_id_addr_byte: assert property (
      (state == S_SETUP && op == OP_ID && nand_o.ale) |-> nand_o.io == ADDR_ID)
      else $error("Identification address byte wrong.");
   chk_we_pulse_len: assert property (
      $fell(nand_o.we_n) |=> !nand_o.we_n ##1 nand_o.we_n)
      else $error("Write strobe width wrong.");
   chk_read_no_drive: assert property (
      !nand_o.re_n |-> nand_o.io_oe_n && !nand_o.ce_n)
      else $error("Host drives data lines during a read.");
   chk_sig_read_limit: assert property (
      (state == S_RE_LO && op == OP_SIG) |-> idx < SIG_LEN)
      else $error("Signature read past four bytes.");
   chk_uid_cpl_check: assert property (
      (uid_act && pos[4] && uid_mis) |=> !uid_ok && uid_bad)
      else $error("Bad identifier copy not flagged.");
   chk_rnd_confirm: assert property (
      (state == S_SETUP && op == OP_RND && step == 3'h3) |-> nand_o.cle
      && nand_o.io == CMD_RND_CFM) else $error("Column move confirm missing.");
   chk_resume_cmd: assert property (
      (state == S_SETUP && op == OP_RESUME) |-> nand_o.cle && nand_o.io == CMD_RESUME)
      else $error("Resume command byte wrong.");
   chk_crc_seed_val: assert property (
      (launch && new_op == OP_PARAM) |=> crc == CRC_INIT && pos == 12'h000)
      else $error("CRC seed wrong at parameter start.");
   chk_status_cmd: assert property (
      (state == S_SETUP && op == OP_STATUS) |-> nand_o.cle && nand_o.io == CMD_STATUS)
      else $error("Status command byte wrong.");
   chk_busy_no_read: assert property (
      (state == S_RB && !rb_s) |=> nand_o.re_n)
      else $error("Read strobe while device busy.");

   cov_id_read: cover property ((op == OP_ID) && cap && (idx == ID_LEN - 10'h001));
   cov_uid_good: cover property ($rose(uid_ok));
   cov_crc_good: cover property ($rose(crc_ok));
   cov_rnd_move: cover property (launch && new_op == OP_RND);
endmodule

// File: hdl/fdr_pkg.sv
// Constants, types and register map of the flash device-information reader.
package fdr_pkg;
   // ==========================================================
   // Clock and pin timing.
   localparam int CLK_NS     = 20;
   localparam int WE_LOW_NS  = 25;
   localparam int WE_HIGH_NS = 25;
   localparam int RE_LOW_NS  = 80;
   localparam int RE_HIGH_NS = 25;
   localparam int TWHR_NS    = 60;
   localparam int TWB_NS     = 100;
   localparam logic [3:0] WE_LO_CYC = 4'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] WE_HI_CYC = 4'((WE_HIGH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] RE_LO_CYC = 4'((RE_LOW_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] RE_HI_CYC = 4'((RE_HIGH_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] TWHR_CYC  = 4'((TWHR_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] TWB_CYC   = 4'((TWB_NS + CLK_NS - 1) / CLK_NS);

   // ==========================================================
   // Device commands, addresses and fixed data.
   localparam logic [7:0]  CMD_READ_ID = 8'h90;
   localparam logic [7:0]  ADDR_ID     = 8'h00;
   localparam logic [7:0]  ADDR_SIG    = 8'h20;
   localparam logic [7:0]  CMD_UID     = 8'hED;
   localparam logic [7:0]  CMD_PARAM   = 8'hEC;
   localparam logic [7:0]  ADDR_INFO   = 8'h00;
   localparam logic [7:0]  CMD_STATUS  = 8'h70;
   localparam logic [7:0]  CMD_RND     = 8'h05;
   localparam logic [7:0]  CMD_RND_CFM = 8'hE0;
   localparam logic [7:0]  CMD_RESUME  = 8'h00;
   localparam logic [7:0]  SIG_B0      = 8'h4F;
   localparam logic [7:0]  SIG_B1      = 8'h4E;
   localparam logic [7:0]  SIG_B2      = 8'h46;
   localparam logic [7:0]  SIG_B3      = 8'h49;
   localparam logic [9:0]  SIG_LEN     = 10'h004;
   localparam logic [9:0]  ID_LEN      = 10'h005;
   localparam logic [7:0]  UID_CPL     = 8'hFF;
   localparam logic [15:0] CRC_POLY    = 16'h8005;
   localparam logic [15:0] CRC_INIT    = 16'h4F4E;
   localparam logic [7:0]  CRC_LO_POS  = 8'hFE;
   localparam logic [7:0]  CRC_HI_POS  = 8'hFF;
   localparam int          STAT_RDY    = 6;

   // ==========================================================
   // Controller register map and fields.
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_STAT  = 8'h04;
   localparam logic [7:0] REG_DATA  = 8'h08;
   localparam logic [7:0] REG_ID0   = 8'h0C;
   localparam logic [7:0] REG_ID1   = 8'h10;
   localparam logic [7:0] REG_UID0  = 8'h14;
   localparam logic [7:0] REG_UID1  = 8'h18;
   localparam logic [7:0] REG_UID2  = 8'h1C;
   localparam logic [7:0] REG_UID3  = 8'h20;
   localparam logic [7:0] REG_CRC   = 8'h24;
   localparam int CTRL_OP_LSB  = 0;
   localparam int CTRL_CNT_LSB = 8;
   localparam int CTRL_COL_LSB = 20;
   localparam logic [2:0] OP_MAX = 3'h6;

   typedef enum logic [2:0] {
      OP_ID, OP_SIG, OP_UID, OP_PARAM, OP_STATUS, OP_RND, OP_RESUME
   } fdr_op_e;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } fdr_bus_s;

   typedef struct packed {
      logic       ce_n;
      logic       cle;
      logic       ale;
      logic       we_n;
      logic       re_n;
      logic       io_oe_n;
      logic [7:0] io;
   } fdr_pin_s;

   localparam fdr_pin_s PIN_IDLE = '{ce_n: 1'h1, cle: 1'h0, ale: 1'h0, we_n: 1'h1,
                                     re_n: 1'h1, io_oe_n: 1'h1, io: 8'h00};
endpackage

// File: sim/fdr_nand_model.sv
// Behavioural flash device answering identification, unique id, parameter and status reads.
module fdr_nand_model (
   input  wire fdr_pkg::fdr_pin_s pins_i,
   output logic [7:0]             io_o,
   output logic                   rb_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import fdr_pkg::*;
   // Maker and part codes are arbitrary.
   localparam logic [7:0] MAKER = 8'h5A;
   localparam logic [7:0] PART  = 8'hA7;
   logic [7:0]  page [256];
   logic [7:0]  unique_identifier [16];
   logic [7:0]  cmd, dout;
   logic [15:0] col, crc;
   logic [2:0]  mode, dmode;
   logic        bad_cpl;
   int          pos, q, viol;
   // ==========================================================
   // Stored data.
   initial begin
      rb_o = 1'b1; dout = 8'h00; mode = 3'h0; dmode = 3'h0; pos = 0; viol = 0;
      bad_cpl = 1'b0; cmd = 8'h00; col = 16'h0000;
      foreach (page[i]) page[i] = 8'h00;
      foreach (unique_identifier[i]) unique_identifier[i] = 8'(i * 37 + 5);
      page[0] = SIG_B0; page[1] = SIG_B1; page[2] = SIG_B2; page[3] = SIG_B3;
      page[4] = 8'h02; page[6] = 8'h10; page[8] = 8'h3F;
      page[81] = 8'h08; page[84] = 8'h80; page[87] = 8'h02; page[90] = 8'h20;
      page[92] = 8'h40; page[97] = 8'h08; page[100] = 8'h01; page[101] = 8'h23;
      page[102] = 8'h01; page[103] = 8'h28; page[110] = 8'h04;
      // Integrity check over bytes 0 to 253.
      crc = CRC_INIT;
      for (int i = 0; i < 254; i++) begin
         for (int b = 7; b >= 0; b--) begin
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ page[i][b]) ? CRC_POLY : 16'h0000);
         end
      end
      page[254] = crc[7:0];
      page[255] = crc[15:8];
   end
   // ==========================================================
   // Command and address latch.
   always @(posedge pins_i.we_n) begin
      if (!pins_i.ce_n && pins_i.cle) begin
         cmd = pins_i.io;
         if (cmd == CMD_STATUS) mode = 3'h4;
         else if (cmd == CMD_RESUME && mode == 3'h4) mode = dmode;
         else if (cmd == CMD_RND_CFM) pos = int'(col);
      end else if (!pins_i.ce_n && pins_i.ale) begin
         if (cmd == CMD_READ_ID) begin
            mode = (pins_i.io == ADDR_SIG) ? 3'h1 : 3'h0; dmode = mode; pos = 0;
         end else if (cmd == CMD_UID || cmd == CMD_PARAM) begin
            mode = (cmd == CMD_UID) ? 3'h2 : 3'h3; dmode = mode; pos = 0;
            rb_o = 1'b0;
            rb_o <= #1000 1'b1;
         end else if (cmd == CMD_RND) col = {pins_i.io, col[15:8]};
      end
   end
   // ==========================================================
   // Data output.
   always @(negedge pins_i.re_n) begin
      if (!pins_i.ce_n) begin
         if (!rb_o) viol++;
         q = pos % 32;
         case (mode)
            3'h0: dout = pos == 0 ? MAKER : pos == 1 ? PART : pos == 2 ? 8'h90 :
                         pos == 3 ? 8'h95 : pos == 4 ? 8'h46 : ~dout;
            3'h1: dout = pos < 4 ? page[pos] : ~dout;
            3'h2: dout = q < 16 ? unique_identifier[q] : ~unique_identifier[q - 16] ^ {7'h00, bad_cpl};
            3'h3: dout = pos < 768 ? page[pos % 256] : ~dout;
            default: dout = {1'b1, rb_o, rb_o, 5'h00};
         endcase
         if (mode != 3'h4) pos++;
      end
   end
   assign io_o = (pins_i.ce_n || pins_i.re_n) ? ~dout : dout;
endmodule

// File: sim/fdr_host_ctrl_bench.sv
// Self-checking bench of the flash device-information reader.
module fdr_host_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import fdr_pkg::*;
   localparam int NT = 19;
   localparam int COLS [NT] = '{4, 6, 8, 80, 81, 84, 86, 87, 90, 92, 96, 97, 100, 101,
                                102, 103, 110, 111, 613};
   localparam logic [7:0] EXPS [NT] = '{8'h02, 8'h10, 8'h3F, 8'h00, 8'h08, 8'h80, 8'h00,
      8'h02, 8'h20, 8'h40, 8'h00, 8'h08, 8'h01, 8'h23, 8'h01, 8'h28, 8'h04, 8'h00, 8'h23};
   logic        core_clk_i, rst_b_i, rb;
   fdr_bus_s    bus;
   fdr_pin_s    pins;
   logic [31:0] rdata, v;
   logic [7:0]  dev_io, io_w;
   int          fails, compares;
   assign io_w = pins.io_oe_n ? dev_io : pins.io;
   fdr_host_ctrl dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .host_bus_i(bus),
      .host_rdata_o(rdata), .nand_io_i(io_w), .nand_rb_i(rb), .nand_o(pins));
   fdr_nand_model dev_u (.pins_i(pins), .io_o(dev_io), .rb_o(rb));
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   // ==========================================================
   // Tasks.
   task automatic end_of_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk_i);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_i);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk_i);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_i);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic run(input logic [2:0] op, input int cnt, input int c, output logic [31:0] d);
      int i;
      wr(REG_CTRL, (32'(c) << CTRL_COL_LSB) | (32'(cnt) << CTRL_CNT_LSB) | 32'(op));
      i = 0;
      do begin
         rd(REG_STAT, d);
         i++;
      end while (d[0] !== 1'b0 && i < 20000);
      if (i >= 20000) begin
         fails++;
         end_of_test();
      end
      rd(REG_DATA, d);
   endtask
   // ==========================================================
   // Sequence.
   initial begin
      bus = '0;
      rst_b_i = 1'b0;
      fails = 0;
      compares = 0;
      repeat (20) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      rd(8'hFC, v);
      check("unmapped read", v, 32'h0);
      run(OP_ID, 5, 0, v);
      check("id last byte", v, 32'h46);
      rd(REG_ID0, v);
      check("id bytes 0-3", v, {8'h95, 8'h90, dev_u.PART, dev_u.MAKER});
      rd(REG_ID1, v);
      check("id byte 4", v[7:0], 8'h46);
      wr(REG_CTRL, 32'h7);
      rd(REG_CTRL, v);
      check("op 7 refused", v[2:0], 3'(OP_ID));
      wr(REG_CTRL, 32'h0000_0901);
      run(OP_ID, 5, 0, v);
      check("signature last", v[7:0], SIG_B3);
      rd(REG_CTRL, v);
      check("busy write refused", v[2:0], 3'(OP_SIG));
      rd(REG_STAT, v);
      check("signature ok", v[2], 1'b1);
      check("signature bytes read", v[25:16], SIG_LEN);
      run(OP_UID, 32, 0, v);
      check("uid complement", v[7:0], 8'(~dev_u.unique_identifier[15]));
      rd(REG_UID0, v);
      check("uid bytes 0-3", v, {dev_u.unique_identifier[3], dev_u.unique_identifier[2], dev_u.unique_identifier[1], dev_u.unique_identifier[0]});
      run(OP_RND, 32, 480, v);
      rd(REG_STAT, v);
      check("last uid copy ok", v[3], 1'b1);
      dev_u.bad_cpl = 1'b1;
      run(OP_UID, 32, 0, v);
      rd(REG_STAT, v);
      check("bad copy flagged", v[3], 1'b0);
      dev_u.bad_cpl = 1'b0;
      run(OP_PARAM, 256, 0, v);
      rd(REG_STAT, v);
      check("parameter crc ok", v[4], 1'b1);
      check("ready seen", v[1], 1'b1);
      rd(REG_CRC, v);
      check("crc check field", v, {dev_u.page[254], 8'h00, CRC_INIT});
      run(OP_STATUS, 1, 0, v);
      check("status ready", v[STAT_RDY], 1'b1);
      run(OP_RESUME, 1, 0, v);
      check("second copy byte 0", v[7:0], SIG_B0);
      for (int i = 0; i < NT; i++) begin
         run(OP_RND, 1, COLS[i], v);
         check("parameter byte", v[7:0], EXPS[i]);
      end
      check("reads only when ready", 32'(dev_u.viol), 32'h0);
      end_of_test();
   end
endmodule
